/* osc_pkg.sv */
// Purpose: Shared constants for the clock source control block
// Assumes: 32-bit APB register access, one word per register
// Notes: Mode and select codes are held here once
package osc_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] TRIM_OFFSET = 8'h04;
  localparam logic [7:0] STAT_OFFSET = 8'h08;

  // Control register fields
  localparam int CTRL_SCS_LSB = 0;
  localparam int CTRL_SEL_LSB = 3;
  localparam int CTRL_SWMUL_BIT = 7;
  localparam int SCS_W = 2;
  localparam int SEL_W = 4;
  localparam int TRIM_W = 6;

  // Reset values
  localparam logic [1:0] SCS_RESET = 2'h0;
  localparam logic [3:0] SEL_RESET = 4'h7;
  localparam logic [5:0] TRIM_RESET = 6'h00;

  // Status register bits
  localparam int STAT_HF_READY = 0;
  localparam int STAT_HF_LOCKED = 1;
  localparam int STAT_HF_STABLE = 2;
  localparam int STAT_MF_READY = 3;
  localparam int STAT_LF_READY = 4;
  localparam int STAT_TIMEOUT = 5;
  localparam int STAT_W = 6;

  // Configuration clock modes
  localparam logic [2:0] MODE_LOW_GAIN = 3'h0;
  localparam logic [2:0] MODE_MID_GAIN = 3'h1;
  localparam logic [2:0] MODE_HIGH_GAIN = 3'h2;
  localparam logic [2:0] MODE_EXT_RC = 3'h3;
  localparam logic [2:0] MODE_INTERNAL = 3'h4;

  // System clock select values
  localparam logic [1:0] SCS_CFG = 2'h0;
  localparam logic [1:0] SCS_TIMER_OSC = 2'h1;
  localparam int SCS_INT_BIT = 1;

  // Frequency select decode: low source, then nine mid outputs, then high
  localparam logic [3:0] SEL_LOW = 4'h0;
  localparam logic [3:0] SEL_HIGH_FIRST = 4'hA;

  // Primary oscillations counted before a crystal clock is used
  localparam int STARTUP_COUNT = 1024;

endpackage

/* startup_if.sv */
// Purpose: Start-up counter handshake between control and counter
// Assumes: Single clock domain
// Notes: start and done are one-cycle pulses
`timescale 1ns/1ps
interface startup_if;
  logic start;
  logic osc_edge;
  logic busy;
  logic done;
  modport ctrl (output start, output osc_edge, input busy, input done);
  modport counter (input start, input osc_edge, output busy, output done);
endinterface

/* startup_cycle_counter.sv */
// Purpose: Counts primary oscillator edges after a start pulse
// Assumes: osc_edge is a one-cycle pulse per oscillation
// Notes: A start while busy restarts the count from zero
`timescale 1ns/1ps
module startup_cycle_counter
  import osc_pkg::*;
#(
  parameter int COUNT = STARTUP_COUNT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control side
  startup_if.counter su
);
  localparam int CW = $clog2(COUNT);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  wire last_edge = busy_q && su.osc_edge && (cnt_q == LAST);

  assign su.busy = busy_q;
  assign su.done = last_edge && !su.start;
  assign busy_d = su.start ? 1'b1 : (last_edge ? 1'b0 : busy_q);
  assign cnt_d = su.start ? '0 : ((busy_q && su.osc_edge) ? cnt_q + 1'b1 : cnt_q);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_done_exact_count: assert property (su.done |-> busy_q && cnt_q == LAST)
    else $error("Start-up done before the full count");
  a_start_sets_busy: assert property (su.start |=> su.busy && cnt_q == '0)
    else $error("Start pulse did not begin a count");
  a_done_ends_busy: assert property (su.done |=> !su.busy)
    else $error("Counter still busy after done");
endmodule

/* clock_source_control.sv */
// Purpose: Clock source control with start-up counting and status
// Assumes: Config word inputs are static; oscillator status inputs synchronous
// Notes: APB slave, zero wait states, registered read data
`timescale 1ns/1ps
module clock_source_control
  import osc_pkg::*;
#(
  parameter int COUNT = STARTUP_COUNT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Configuration word
  input wire logic [2:0] cfg_clock_mode_i,
  input wire logic cfg_multiplier_enable_i,
  input wire logic clock_out_pin_enable_i,
  // Start-up events
  input wire logic powerup_delay_en_i,
  input wire logic powerup_delay_done_i,
  input wire logic wake_i,
  input wire logic primary_osc_edge_i,
  // Low oscillator dependents
  input wire logic watchdog_en_i,
  input wire logic failsafe_en_i,
  input wire logic lf_tick_i,
  // Analog oscillator status
  input wire logic hf_running_i,
  input wire logic hf_within_coarse_i,
  input wire logic hf_within_fine_i,
  input wire logic mf_running_i,
  input wire logic lf_running_i,
  // Core control
  output logic exec_hold_o,
  output logic ext_osc_active_o,
  output logic [1:0] sys_clock_src_o,
  output logic [3:0] freq_select_o,
  // Oscillator control
  output logic multiplier_en_o,
  output logic hf_osc_en_o,
  output logic hf_loop_en_o,
  output logic mf_osc_en_o,
  output logic lf_osc_en_o,
  output logic [5:0] mf_trim_o,
  output logic timer_tick_o,
  // Pin function
  output logic primary_pin_gpio_o,
  output logic secondary_pin_gpio_o,
  output logic secondary_pin_clkout_o
);

  typedef enum logic [1:0] {ST_POWERUP, ST_COUNT, ST_RUN} state_t;

  state_t state_q;
  state_t state_d;
  logic [SCS_W-1:0] scs_q;
  logic [SEL_W-1:0] sel_q;
  logic sw_mul_q;
  logic [TRIM_W-1:0] trim_q;
  logic timeout_q;
  logic timeout_d;
  logic hf_ready_q;
  logic hf_locked_q;
  logic hf_stable_q;
  logic mf_ready_q;
  logic lf_ready_q;
  logic tick_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  startup_if su ();

  startup_cycle_counter #(
    .COUNT(COUNT)
  ) u_counter (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .su(su)
  );

  // Bus decode
  wire hit_ctrl = (paddr_i == CTRL_OFFSET);
  wire hit_trim = (paddr_i == TRIM_OFFSET);
  wire hit_stat = (paddr_i == STAT_OFFSET);
  wire hit_any = hit_ctrl || hit_trim || hit_stat;
  wire setup = psel_i && !penable_i;
  wire access = psel_i && penable_i;
  wire wr_ctrl = access && pwrite_i && hit_ctrl;
  wire wr_trim = access && pwrite_i && hit_trim;

  assign pready_o = 1'b1;
  assign pslverr_o = access && !hit_any;

  // Mode decode
  wire crystal_mode = (cfg_clock_mode_i == MODE_LOW_GAIN) ||
                      (cfg_clock_mode_i == MODE_MID_GAIN) ||
                      (cfg_clock_mode_i == MODE_HIGH_GAIN);
  wire internal_mode = (cfg_clock_mode_i == MODE_INTERNAL);
  wire internal_sel = scs_q[SCS_INT_BIT];
  wire internal_req = internal_mode || internal_sel;

  // Frequency select decode
  wire sel_low = (sel_q == SEL_LOW);
  wire sel_high = (sel_q >= SEL_HIGH_FIRST);
  wire sel_mid = !sel_low && !sel_high;

  // Oscillator enables
  assign hf_osc_en_o = sel_high && internal_req;
  assign hf_loop_en_o = hf_osc_en_o;
  // The high source needs the mid source as its loop reference
  assign mf_osc_en_o = (sel_mid && internal_req) || hf_osc_en_o;
  wire lf_dependents = watchdog_en_i || failsafe_en_i ||
                       (powerup_delay_en_i && state_q == ST_POWERUP);
  assign lf_osc_en_o = (sel_low && internal_req) || lf_dependents;
  assign timer_tick_o = tick_q;

  // Multiplier: config bit wins, software bit is ignored under it
  assign multiplier_en_o = cfg_multiplier_enable_i || sw_mul_q;

  // Trim only reaches the mid source; the low source has no trim input
  assign mf_trim_o = trim_q;

  // Pins
  wire secondary_free = !crystal_mode;
  assign primary_pin_gpio_o = internal_mode;
  assign secondary_pin_clkout_o = secondary_free && clock_out_pin_enable_i;
  assign secondary_pin_gpio_o = secondary_free && !clock_out_pin_enable_i;

  // Clock source
  assign sys_clock_src_o = scs_q;
  assign freq_select_o = sel_q;
  assign ext_osc_active_o = (scs_q == SCS_CFG) && !internal_mode &&
                            (timeout_q || !crystal_mode);
  assign exec_hold_o = (state_q != ST_RUN);

  // Start-up sequencing
  wire pwrup_ok = !powerup_delay_en_i || powerup_delay_done_i;
  assign su.osc_edge = primary_osc_edge_i;
  assign su.start = crystal_mode &&
                    ((state_q == ST_POWERUP && pwrup_ok) ||
                     (state_q == ST_RUN && wake_i));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_POWERUP: begin
        if (pwrup_ok) begin
          state_d = crystal_mode ? ST_COUNT : ST_RUN;
        end
      end
      ST_COUNT: begin
        if (su.done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wake_i && crystal_mode) begin
          state_d = ST_COUNT;
        end
      end
    endcase
  end

  // Timeout flag drops when a new count begins
  assign timeout_d = su.done ? 1'b1 : (su.start ? 1'b0 : timeout_q);

  // Read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    rdata_d = '0;
    if (hit_ctrl) begin
      rdata_d[CTRL_SCS_LSB +: SCS_W] = scs_q;
      rdata_d[CTRL_SEL_LSB +: SEL_W] = sel_q;
      rdata_d[CTRL_SWMUL_BIT] = sw_mul_q;
    end else if (hit_trim) begin
      rdata_d[TRIM_W-1:0] = trim_q;
    end else if (hit_stat) begin
      rdata_d[STAT_HF_READY] = hf_ready_q;
      rdata_d[STAT_HF_LOCKED] = hf_locked_q;
      rdata_d[STAT_HF_STABLE] = hf_stable_q;
      rdata_d[STAT_MF_READY] = mf_ready_q;
      rdata_d[STAT_LF_READY] = lf_ready_q;
      rdata_d[STAT_TIMEOUT] = timeout_q;
    end
  end
  assign prdata_o = rdata_q;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (setup && !pwrite_i) begin
      rdata_q <= rdata_d;
    end
  end

  // Software registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scs_q <= SCS_RESET;
      sel_q <= SEL_RESET;
      sw_mul_q <= 1'b0;
    end else if (wr_ctrl) begin
      scs_q <= pwdata_i[CTRL_SCS_LSB +: SCS_W];
      sel_q <= pwdata_i[CTRL_SEL_LSB +: SEL_W];
      sw_mul_q <= pwdata_i[CTRL_SWMUL_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trim_q <= TRIM_RESET;
    end else if (wr_trim) begin
      trim_q <= pwdata_i[TRIM_W-1:0];
    end
  end

  // Control state
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_POWERUP;
      timeout_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timeout_q <= timeout_d;
      tick_q <= lf_tick_i && lf_ready_q;
    end
  end

  // Status flags follow running oscillators and drop when disabled
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hf_ready_q <= 1'b0;
      hf_locked_q <= 1'b0;
      hf_stable_q <= 1'b0;
      mf_ready_q <= 1'b0;
      lf_ready_q <= 1'b0;
    end else begin
      hf_ready_q <= hf_osc_en_o && hf_running_i;
      hf_locked_q <= hf_osc_en_o && hf_running_i && hf_within_coarse_i;
      hf_stable_q <= hf_osc_en_o && hf_running_i && hf_within_fine_i;
      mf_ready_q <= mf_osc_en_o && mf_running_i;
      lf_ready_q <= lf_osc_en_o && lf_running_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_hold_during_count: assert property (su.busy |-> exec_hold_o)
    else $error("Execution not held during start-up count");
  a_done_sets_flag: assert property (su.done |=> timeout_q && !exec_hold_o)
    else $error("Timeout flag or release missing after count");
  a_mult_config_wins: assert property (cfg_multiplier_enable_i |-> multiplier_en_o)
    else $error("Multiplier off with config enable set");
  a_mult_sw_enable: assert property (
    $past(wr_ctrl) && $past(pwdata_i[CTRL_SWMUL_BIT]) |-> multiplier_en_o)
    else $error("Software multiplier enable ignored");
  a_skip_count_mode: assert property (
    state_q == ST_RUN && !crystal_mode |=> !exec_hold_o)
    else $error("Non-crystal mode stalled execution");
  a_wake_restarts: assert property (
    state_q == ST_RUN && wake_i && crystal_mode |=> exec_hold_o && su.busy)
    else $error("Wake did not start a crystal count");
  a_sel_after_reset: assert property (
    $past(sys_rst_i) |-> sel_q == SEL_RESET && scs_q == SCS_RESET)
    else $error("Select fields wrong after reset");
  a_hf_flags_clear: assert property (
    !hf_osc_en_o |=> !hf_ready_q && !hf_locked_q && !hf_stable_q)
    else $error("High flags stayed set while disabled");
  a_lf_dependents_on: assert property (
    (watchdog_en_i || failsafe_en_i) |-> lf_osc_en_o)
    else $error("Low oscillator off with dependents enabled");
  a_trim_no_stall: assert property (
    wr_trim && state_q == ST_RUN && !wake_i |=>
    !exec_hold_o && mf_trim_o == $past(pwdata_i[TRIM_W-1:0]))
    else $error("Trim write stalled execution");
  a_crystal_pins_held: assert property (
    crystal_mode |-> !secondary_pin_gpio_o && !secondary_pin_clkout_o && !primary_pin_gpio_o)
    else $error("Oscillator pin released in a crystal mode");
  a_clock_out_pin: assert property (
    !crystal_mode && clock_out_pin_enable_i |-> secondary_pin_clkout_o && !secondary_pin_gpio_o)
    else $error("Clock out not on the free secondary pin");
  a_primary_pin_free: assert property (
    internal_mode |-> primary_pin_gpio_o)
    else $error("Primary pin not released in internal mode");
  a_loop_feeds_high: assert property (
    hf_osc_en_o |-> hf_loop_en_o && mf_osc_en_o)
    else $error("High source on without its loop and reference");
  a_high_needs_internal: assert property (
    hf_osc_en_o |-> cfg_clock_mode_i == MODE_INTERNAL || scs_q[SCS_INT_BIT])
    else $error("High oscillator on outside internal operation");
  a_hf_ready_follows: assert property (
    hf_osc_en_o && hf_running_i |=> hf_ready_q)
    else $error("High ready flag missing while running");
  a_mf_ready_follows: assert property (
    mf_osc_en_o && mf_running_i |=> mf_ready_q)
    else $error("Mid ready flag missing while running");
  a_lf_ready_follows: assert property (
    lf_osc_en_o && lf_running_i |=> lf_ready_q)
    else $error("Low ready flag missing while running");
  a_select_write: assert property (
    wr_ctrl |=> sys_clock_src_o == $past(pwdata_i[CTRL_SCS_LSB +: SCS_W]))
    else $error("Clock select write not applied");

  c_count_done: cover property (su.done ##1 timeout_q);
  c_wake_count: cover property (wake_i && crystal_mode && state_q == ST_RUN);
  c_hf_stable: cover property (hf_stable_q);
  c_internal_sel: cover property (wr_ctrl ##1 internal_sel);
  c_clock_out: cover property (secondary_pin_clkout_o && !crystal_mode);
endmodule

/* osc_far_side.sv */
// Purpose: Far-side model of the crystal and the analog internal oscillators
// Assumes: Enables are levels on clk_i; crystal gives one edge every third cycle
// Notes: Settling is staged so locked trails ready and stable trails locked
`timescale 1ns/1ps
module osc_far_side (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic xtal_run_i,
  input wire logic hf_en_i,
  input wire logic mf_en_i,
  input wire logic lf_en_i,
  // Status
  output logic osc_edge_o,
  output logic hf_run_o,
  output logic hf_coarse_o,
  output logic hf_fine_o,
  output logic mf_run_o,
  output logic lf_run_o,
  output logic lf_tick_o
);
  logic [1:0] div_q;
  logic [2:0] lf_div_q;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q <= 2'h0;
      lf_div_q <= 3'h0;
      osc_edge_o <= 1'b0;
      {hf_run_o, hf_coarse_o, hf_fine_o, mf_run_o, lf_run_o, lf_tick_o} <= 6'h00;
    end else begin
      div_q <= (xtal_run_i && div_q != 2'h2) ? div_q + 2'h1 : 2'h0;
      osc_edge_o <= xtal_run_i && div_q == 2'h2;
      hf_run_o <= hf_en_i;
      hf_coarse_o <= hf_run_o & hf_en_i;
      hf_fine_o <= hf_coarse_o & hf_en_i;
      mf_run_o <= mf_en_i;
      lf_run_o <= lf_en_i;
      lf_div_q <= lf_div_q + 3'h1;
      lf_tick_o <= lf_run_o && lf_div_q == 3'h7;
    end
  end
endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the clock source control block
// Assumes: Count shortened to 8 edges; far side from osc_far_side
// Notes: Random register traffic from a fixed seed, corners first
`timescale 1ns/1ps
module tb_top;
  import osc_pkg::*;
  localparam int CNT = 8;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, xtal_run = 1'b0;
  logic [2:0] cfg_clock_mode_i = MODE_LOW_GAIN;
  logic cfg_multiplier_enable_i = 1'b0, clock_out_pin_enable_i = 1'b0;
  logic powerup_delay_en_i = 1'b1, powerup_delay_done_i = 1'b0, wake_i = 1'b0;
  logic watchdog_en_i = 1'b0, failsafe_en_i = 1'b0;
  logic primary_osc_edge_i, lf_tick_i, hf_running_i, hf_within_coarse_i, hf_within_fine_i;
  logic mf_running_i, lf_running_i, exec_hold_o, ext_osc_active_o, multiplier_en_o;
  logic hf_osc_en_o, hf_loop_en_o, mf_osc_en_o, lf_osc_en_o, timer_tick_o;
  logic primary_pin_gpio_o, secondary_pin_gpio_o, secondary_pin_clkout_o;
  logic [1:0] sys_clock_src_o;
  logic [3:0] freq_select_o;
  logic [5:0] mf_trim_o;
  int err_count = 0;
  int check_count = 0;
  always #12.5 clk_i = ~clk_i;
  clock_source_control #(.COUNT(CNT)) clock_source_control_i (.*);
  osc_far_side osc_far_side_i (.clk_i, .sys_rst_i, .xtal_run_i(xtal_run),
    .hf_en_i(hf_osc_en_o), .mf_en_i(mf_osc_en_o), .lf_en_i(lf_osc_en_o),
    .osc_edge_o(primary_osc_edge_i), .hf_run_o(hf_running_i), .hf_coarse_o(hf_within_coarse_i),
    .hf_fine_o(hf_within_fine_i), .mf_run_o(mf_running_i), .lf_run_o(lf_running_i),
    .lf_tick_o(lf_tick_i));
  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      check(1'b0, 1'b1, "bus timeout");
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r & m, x, "read data");
  endtask
  task automatic do_reset(input logic [2:0] m);
    sys_rst_i <= 1'b1;
    cfg_clock_mode_i <= m;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
  endtask
  // Counts crystal edges seen while execution is held
  task automatic run_count(output int edges);
    edges = 0;
    for (int n = 0; n < 400 && exec_hold_o !== 1'b0; n++) begin
      @(posedge clk_i);
      #1;
      if (primary_osc_edge_i === 1'b1 && exec_hold_o === 1'b1) edges++;
    end
    if (exec_hold_o !== 1'b0) begin
      check(1'b0, 1'b1, "hold timeout");
      print_verdict();
    end
  endtask
  // Expected {high, mid, low} enables
  function automatic logic [2:0] exp_en(input logic [2:0] m, input logic [3:0] s,
                                        input logic [1:0] c, input logic w, input logic f);
    logic on;
    on = (m == MODE_INTERNAL) || c[SCS_INT_BIT];
    return {on && s >= SEL_HIGH_FIRST, on && s != SEL_LOW, (s == SEL_LOW && on) || w || f};
  endfunction
  initial begin
    int edges;
    logic [31:0] d;
    logic e;
    logic [3:0] sel;
    logic [1:0] system_clock_select;
    logic sw;
    logic [5:0] t;
    logic [2:0] ex;
    logic [3:0] corner [4] = '{4'h0, 4'h9, 4'hA, 4'hF};
    void'($urandom(32'hCB7F895E));
    do_reset(MODE_LOW_GAIN);
    rd_chk(CTRL_OFFSET, 32'hFFFFFFFF, 32'h00000038);
    rd_chk(TRIM_OFFSET, 32'hFFFFFFFF, 32'h0);
    xtal_run <= 1'b1;
    repeat (30) @(posedge clk_i);
    check(exec_hold_o, 1'b1, "hold before power-up delay");
    xtal_run <= 1'b0;
    repeat (4) @(posedge clk_i);
    powerup_delay_done_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    xtal_run <= 1'b1;
    run_count(edges);
    check(edges, CNT, "start-up edges");
    rd_chk(STAT_OFFSET, 32'h20, 32'h20);
    check(ext_osc_active_o, 1'b1, "external active");
    // Wake with the crystal stopped: hold must stay until edges return
    xtal_run <= 1'b0;
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(exec_hold_o, 1'b1, "hold after wake");
    xtal_run <= 1'b1;
    run_count(edges);
    check(edges, CNT, "wake edges");
    for (int m = 3; m < 8; m++) begin
      clock_out_pin_enable_i <= 1'($urandom);
      do_reset(3'(m));
      repeat (4) @(posedge clk_i);
      check(exec_hold_o, 1'b0, "no start-up wait");
      check(primary_pin_gpio_o, m == 4, "primary pin");
      check(secondary_pin_clkout_o, clock_out_pin_enable_i, "clock out");
      check(secondary_pin_gpio_o, !clock_out_pin_enable_i, "secondary gpio");
    end
    for (int k = 0; k < 2; k++) begin
      do_reset(k == 0 ? MODE_INTERNAL : MODE_EXT_RC);
      for (int i = 0; i < 12; i++) begin
        sel = (i < 4) ? corner[i] : 4'($urandom);
        system_clock_select = 2'($urandom);
        sw = 1'($urandom);
        cfg_multiplier_enable_i <= 1'($urandom);
        watchdog_en_i <= (i > 5) && 1'($urandom);
        failsafe_en_i <= (i > 5) && 1'($urandom);
        wr(CTRL_OFFSET, {24'($urandom), sw, sel, 1'b0, system_clock_select});
        repeat (8) @(posedge clk_i);
        ex = exp_en(cfg_clock_mode_i, sel, system_clock_select, watchdog_en_i, failsafe_en_i);
        check(sys_clock_src_o, system_clock_select, "clock select");
        check(freq_select_o, sel, "freq select");
        check(multiplier_en_o, cfg_multiplier_enable_i | sw, "multiplier");
        check(hf_osc_en_o, ex[2], "high enable");
        check(hf_loop_en_o, ex[2], "loop enable");
        check(mf_osc_en_o, ex[1], "mid enable");
        check(lf_osc_en_o, ex[0], "low enable");
        rd_chk(STAT_OFFSET, 32'h1F, {27'h0, ex[0], ex[1], {3{ex[2]}}});
      end
    end
    // Low source kept on by a dependent: one timer tick every eight cycles
    watchdog_en_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    edges = 0;
    repeat (16) begin
      @(posedge clk_i);
      #1;
      if (timer_tick_o === 1'b1) edges++;
    end
    check(edges, 2, "low ticks");
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? 6'h1F : (i == 1) ? 6'h20 : 6'($urandom);
      wr(TRIM_OFFSET, {26'($urandom), t});
      rd_chk(TRIM_OFFSET, 32'hFFFFFFFF, {26'h0, t});
      check(mf_trim_o, t, "trim out");
      check(exec_hold_o, 1'b0, "no stall on trim");
    end
    apb(1'b0, 8'h0C, 32'h0, d, e);
    check(d, 32'h0, "unmapped read");
    check(e, 1'b1, "unmapped error");
    wr(STAT_OFFSET, 32'hFFFFFFFF);
    rd_chk(STAT_OFFSET, 32'hFFFFFFC0, 32'h0);
    print_verdict();
  end
endmodule
